/* stc_defs.svh */
// Register offsets, field positions, reset values and counts of the system time block
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define TIME_W      42
`define EXT_LSB     16
`define FLD_LSB     9
`define PRE_WRAP    9'h12b
`define ROLL_FIELD  6'h3f
`define A_CTRL      8'h00
`define A_EXT       8'h04
`define A_STC_LO    8'h08
`define A_STC_HI    8'h0c
`define A_MAXD      8'h10
`define A_GUARD     8'h14
`define A_MARGIN    8'h18
`define A_STEP      8'h1c
`define A_AOFF      8'h20
`define A_VOFF      8'h24
`define A_STATUS    8'h28
`define A_MASK      8'h2c
`define A_MEAN      8'h30
`define A_STATE     8'h34
`define C_REF       0
`define C_AEN       1
`define C_VEN       2
`define C_LIP       3
`define C_FORCE     4
`define C_CHG       5
`define C_ACHG      6
`define S_ROLL      0
`define S_REF       1
`define S_DROP      2
`define S_CORR      3
`define S_LIP       4
`define ST_W        5
`define MAXD_RST    32'h0000ffff
`define GUARD_RST   32'h0000ffff
`define MARGIN_RST  32'h00000000
`define STEP_RST    32'h00000001
`endif

/* stc_pkg.sv */
// Types of the system time block
package stc_pkg;
  typedef logic [41:0] time_t;
  typedef enum logic [2:0] {
    SYNC_FREE   = 3'b001,
    SYNC_ARMED  = 3'b010,
    SYNC_LOCKED = 3'b100
  } sync_e;
  typedef struct packed {
    time_t       stc;
    time_t       vid;
    time_t       aud;
    logic        aud_ld;
    logic        vid_ld;
    sync_e       st;
    logic [3:0]  ctl;
    logic [31:0] maxd;
    logic [31:0] guard;
    logic [31:0] margin;
    logic [31:0] step;
    logic [31:0] aoff;
    logic [31:0] voff;
    logic [4:0]  sts;
    logic [4:0]  msk;
    logic        low;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } top_s;
  typedef struct packed {
    logic [7:0][41:0] dbuf;
    logic [2:0]       wp;
    logic             stored;
    logic             dropped;
    logic             accepted;
    time_t            mean;
  } flt_s;
endpackage

/* stamp_if.sv */
// Link between the time block and its stamp filter
`timescale 1ns/1ps
`default_nettype none
interface stamp_if;
  import stc_pkg::*;
  logic  valid;
  time_t stamp;
  time_t stc;
  time_t max_d;
  time_t guard;
  time_t mean;
  logic  stored;
  logic  dropped;
  logic  accepted;
  modport src (output valid, stamp, stc, max_d, guard, input mean, stored, dropped, accepted);
  modport flt (input valid, stamp, stc, max_d, guard, output mean, stored, dropped, accepted);
endinterface
`default_nettype wire

/* stamp_filter.sv */
// Stamp delta window with running mean and guard check
`timescale 1ns/1ps
`default_nettype none
module stamp_filter #(
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  stamp_if.flt     f
);
  import stc_pkg::*;
  flt_s        r;
  flt_s        n;
  logic [44:0] sum;
  time_t       delta;
  time_t       dev;

  if (DEPTH != 8) begin : g_chk
    $error("stamp_filter depth must be 8");
  end

  always_comb begin
    n = r;
    n.stored = 1'b0;
    n.dropped = 1'b0;
    n.accepted = 1'b0;
    delta = f.stamp - f.stc;
    dev = f.stamp - r.mean;
    if (f.valid) begin
      if (delta > f.max_d) begin
        n.dropped = 1'b1;
      end else begin
        n.dbuf[r.wp] = delta;
        n.wp = r.wp + 3'h1;
        n.stored = 1'b1;
        n.accepted = (dev <= f.guard);
      end
    end
    sum = '0;
    for (int i = 0; i < DEPTH; i++) begin
      sum = sum + {3'h0, n.dbuf[i]};
    end
    n.mean = sum[44:3];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign f.mean = r.mean;
  assign f.stored = r.stored;
  assign f.dropped = r.dropped;
  assign f.accepted = r.accepted;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_drop_big: assert property (f.valid && (f.stamp - f.stc) > f.max_d |=> f.dropped && !f.stored)
    else $error("oversized stamp delta not dropped");
  a_store_ptr: assert property (f.valid && (f.stamp - f.stc) <= f.max_d |=> r.wp == $past(r.wp) + 3'h1)
    else $error("stored delta did not advance pointer");
  a_guard_gate: assert property (f.accepted |-> $past(f.stamp - r.mean) <= $past(f.guard))
    else $error("stamp accepted outside guard window");
endmodule
`default_nettype wire

/* system_time_clock_sync.sv */
// System time counter with reference load, stamp tracking and clock correction
`include "stc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module system_time_clock_sync (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          ref_valid,
  input  wire stc_pkg::time_t ref_value,
  input  wire logic          stamp_valid,
  input  wire stc_pkg::time_t stamp_value,
  input  wire stc_pkg::time_t video_stamp_now,
  input  wire logic          audio_xrun,
  output stc_pkg::time_t     system_time_count,
  output stc_pkg::time_t     video_time_count,
  output stc_pkg::time_t     audio_time_count,
  output logic               video_time_load,
  output logic               audio_time_load,
  output logic               fast_interrupt
);
  import stc_pkg::*;

  top_s        r;
  top_s        n;
  logic        setup;
  logic        wr;
  logic        hit;
  logic [31:0] rd;
  logic        tick;
  logic        roll;
  logic        lock;
  logic        late;
  logic        corr;
  logic [4:0]  ev;
  logic [4:0]  w1c;
  logic [31:0] aoff_new;
  logic [31:0] voff_new;

  stamp_if sif ();

  stamp_filter #(
    .DEPTH (8)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (sif.flt)
  );

  assign sif.valid = stamp_valid;
  assign sif.stamp = stamp_value;
  assign sif.stc = r.stc;
  assign sif.max_d = {10'h000, r.maxd};
  assign sif.guard = {10'h000, r.guard};

  function automatic time_t inc_t(time_t t);
    if (t[8:0] == `PRE_WRAP) begin
      inc_t = {t[41:9] + 33'h1, 9'h000};
    end else begin
      inc_t = {t[41:9], t[8:0] + 9'h001};
    end
  endfunction

  function automatic time_t sext(logic [31:0] v);
    sext = {{10{v[31]}}, v};
  endfunction

  always_comb begin
    setup = psel & ~penable;
    hit = 1'b1;
    case (paddr)
      `A_CTRL:   rd = {25'h0, 3'h0, r.ctl};
      `A_EXT:    rd = {6'h00, r.stc[41:16]};
      `A_STC_LO: rd = r.stc[31:0];
      `A_STC_HI: rd = {22'h0, r.stc[41:32]};
      `A_MAXD:   rd = r.maxd;
      `A_GUARD:  rd = r.guard;
      `A_MARGIN: rd = r.margin;
      `A_STEP:   rd = r.step;
      `A_AOFF:   rd = r.aoff;
      `A_VOFF:   rd = r.voff;
      `A_STATUS: rd = {27'h0, r.sts};
      `A_MASK:   rd = {27'h0, r.msk};
      `A_MEAN:   rd = sif.mean[31:0];
      `A_STATE:  rd = {29'h0, r.st};
      default: begin
        rd = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    n = r;
    wr = psel & penable & r.pready & pwrite & ~r.pslverr;
    tick = (r.stc[8:0] == `PRE_WRAP);
    roll = tick & (r.stc[14:9] == `ROLL_FIELD);
    lock = (r.st == SYNC_LOCKED);
    late = (r.stc + sext(r.margin)) > video_stamp_now;
    corr = roll & lock & r.ctl[`C_VEN] & late & r.low;
    ev = '0;
    w1c = '0;
    aoff_new = r.aoff;
    voff_new = r.voff;
    n.aud_ld = 1'b0;
    n.vid_ld = 1'b0;
    n.pready = setup;
    n.pslverr = setup & ~hit;
    n.prdata = setup ? rd : 32'h0;
    n.stc = inc_t(r.stc);
    n.vid = inc_t(r.vid);
    if (roll) begin
      ev[`S_ROLL] = 1'b1;
    end
    if (wr) begin
      case (paddr)
        `A_CTRL: begin
          n.ctl = pwdata[3:0];
          if (!pwdata[`C_REF]) begin
            n.st = SYNC_FREE;
          end else if (r.st == SYNC_FREE || pwdata[`C_CHG]) begin
            n.st = SYNC_ARMED;
          end
          if (pwdata[`C_CHG]) begin
            n.low = 1'b0;
          end
          if (pwdata[`C_ACHG]) begin
            aoff_new = 32'h0;
          end
        end
        `A_EXT:    n.stc[41:16] = pwdata[25:0];
        `A_MAXD:   n.maxd = pwdata;
        `A_GUARD:  n.guard = pwdata;
        `A_MARGIN: n.margin = pwdata;
        `A_STEP:   n.step = pwdata;
        `A_AOFF:   aoff_new = pwdata;
        `A_VOFF:   voff_new = pwdata;
        `A_STATUS: w1c = pwdata[4:0];
        `A_MASK:   n.msk = pwdata[4:0];
        default: begin
          n.ctl = n.ctl;
        end
      endcase
    end
    if (roll && lock && r.ctl[`C_VEN]) begin
      n.low = late & ~r.low;
    end
    if (corr) begin
      voff_new = r.voff - r.step;
      n.vid = inc_t(r.vid) - sext(r.step);
      ev[`S_CORR] = 1'b1;
      if (r.ctl[`C_AEN]) begin
        aoff_new = r.ctl[`C_LIP] ? voff_new : r.aoff - r.step;
      end
    end
    n.aoff = aoff_new;
    n.voff = voff_new;
    if (roll && r.ctl[`C_AEN]) begin
      n.aud = r.stc + sext(aoff_new);
      n.aud_ld = 1'b1;
    end
    if (wr && paddr == `A_CTRL && pwdata[`C_FORCE]) begin
      n.vid = r.stc + sext(voff_new);
      n.vid_ld = 1'b1;
    end
    if (r.st == SYNC_ARMED && ref_valid) begin
      n.stc = ref_value;
      n.st = SYNC_LOCKED;
      ev[`S_REF] = 1'b1;
      if (r.ctl[`C_VEN]) begin
        n.vid = ref_value;
        n.vid_ld = 1'b1;
      end
      if (r.ctl[`C_AEN]) begin
        n.aud = ref_value;
        n.aud_ld = 1'b1;
      end
    end
    if (sif.dropped || (sif.stored && !sif.accepted)) begin
      ev[`S_DROP] = 1'b1;
    end
    if (r.ctl[`C_LIP] && audio_xrun) begin
      ev[`S_LIP] = 1'b1;
    end
    n.sts = (r.sts & ~w1c) | ev;
    n.irq = |(n.sts & n.msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= SYNC_FREE;
      r.maxd <= `MAXD_RST;
      r.guard <= `GUARD_RST;
      r.margin <= `MARGIN_RST;
      r.step <= `STEP_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign system_time_count = r.stc;
  assign video_time_count = r.vid;
  assign audio_time_count = r.aud;
  assign video_time_load = r.vid_ld;
  assign audio_time_load = r.aud_ld;
  assign fast_interrupt = r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pre_range: assert property (r.stc[8:0] <= `PRE_WRAP)
    else $error("prescaler beyond wrap value");

  a_pre_wrap: assert property (tick && !ref_valid && !wr |=> r.stc[8:0] == 9'h0 && r.stc[15:9] == $past(r.stc[15:9]) + 7'h1)
    else $error("prescaler wrap did not bump field");

  a_roll_flag: assert property (roll |=> r.sts[`S_ROLL])
    else $error("rollover did not set status");

  a_irq_level: assert property (##1 fast_interrupt == |($past(n.sts) & $past(n.msk)))
    else $error("interrupt level mismatch");

  a_ref_load: assert property (r.st == SYNC_ARMED && ref_valid |=> r.stc == $past(ref_value) && lock)
    else $error("reference sample not loaded");

  a_aud_reload: assert property (roll && r.ctl[`C_AEN] && !corr && !ref_valid && !wr |=> audio_time_load && audio_time_count == $past(r.stc + sext(r.aoff)))
    else $error("audio clock not reloaded at rollover");

  a_vid_force: assert property (wr && paddr == `A_CTRL && pwdata[`C_FORCE] && !ref_valid |=> video_time_load)
    else $error("forced video reset not applied");

  a_corr_two: assert property (corr |=> r.sts[`S_CORR] && r.voff == $past(r.voff) - $past(r.step))
    else $error("correction step not applied");

  a_pready_pulse: assert property (
    setup |=> pready)
    else $error("no ready after setup");

  a_pready_idle: assert property (
    !setup |=> !pready)
    else $error("ready without setup");

  a_slverr_map: assert property (
    setup && !hit |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  a_rdata_hold: assert property (
    setup && hit |=> !pslverr && prdata == $past(rd))
    else $error("read data mismatch");

  a_stc_step: assert property (
    !(r.st == SYNC_ARMED && ref_valid) && !(wr && paddr == `A_EXT) |=> system_time_count == $past(inc_t(r.stc)))
    else $error("time count did not advance");

  a_ext_write: assert property (
    wr && paddr == `A_EXT && !(r.st == SYNC_ARMED && ref_valid) |=> r.stc[41:16] == $past(pwdata[25:0]))
    else $error("extension write not applied");

  a_free_state: assert property (
    wr && paddr == `A_CTRL && !pwdata[`C_REF] && !(r.st == SYNC_ARMED && ref_valid) |=> r.st == SYNC_FREE)
    else $error("reference off did not free-run");

  a_arm_state: assert property (
    wr && paddr == `A_CTRL && pwdata[`C_REF] && r.st == SYNC_FREE |=> r.st == SYNC_ARMED)
    else $error("reference channel not armed");

  a_free_nolock: assert property (
    r.st == SYNC_FREE |=> r.st != SYNC_LOCKED)
    else $error("locked without arming");

  a_ref_vid: assert property (
    r.st == SYNC_ARMED && ref_valid && r.ctl[`C_VEN] |=> video_time_load && video_time_count == $past(ref_value))
    else $error("video clock not loaded by reference");

  a_ref_aud: assert property (
    r.st == SYNC_ARMED && ref_valid && r.ctl[`C_AEN] |=> audio_time_load && audio_time_count == $past(ref_value))
    else $error("audio clock not loaded by reference");

  a_vid_free: assert property (
    !corr && !(wr && paddr == `A_CTRL && pwdata[`C_FORCE]) && !(r.st == SYNC_ARMED && ref_valid) |=> video_time_count == $past(inc_t(r.vid)))
    else $error("video clock did not advance");

  a_aud_hold: assert property (
    !(roll && r.ctl[`C_AEN]) && !(r.st == SYNC_ARMED && ref_valid) |=> audio_time_count == $past(r.aud) && !audio_time_load)
    else $error("audio clock changed between reloads");

  a_aoff_clear: assert property (
    wr && paddr == `A_CTRL && pwdata[`C_ACHG] && !corr |=> r.aoff == 32'h0)
    else $error("audio offset not cleared");

  a_lip_copy: assert property (
    corr && r.ctl[`C_AEN] && r.ctl[`C_LIP] |=> r.aoff == r.voff)
    else $error("video offset not copied to audio");

  a_lip_reload: assert property (
    corr && r.ctl[`C_AEN] |=> audio_time_load)
    else $error("audio clock not rewritten after correction");

  a_first_late: assert property (
    roll && lock && r.ctl[`C_VEN] && late && !r.low && !wr |=> r.low && r.voff == $past(r.voff))
    else $error("single late check corrected clock");

  a_status_w1c: assert property (
    wr && paddr == `A_STATUS && pwdata[`S_ROLL] && !roll |=> !r.sts[`S_ROLL])
    else $error("status bit not cleared by write");

  a_ref_flag: assert property (
    r.st == SYNC_ARMED && ref_valid |=> r.sts[`S_REF])
    else $error("reference load not flagged");

  a_lip_fail: assert property (r.ctl[`C_LIP] && audio_xrun |=> r.sts[`S_LIP])
    else $error("lip-sync fault not flagged");
endmodule
`default_nettype wire

/* stream_source.sv */
// Far-side model feeding reference samples, video stamps and audio buffer state
`timescale 1ns/1ps
`default_nettype none
module stream_source (
  input  wire logic      pclk,
  output logic           ref_valid,
  output stc_pkg::time_t ref_value,
  output logic           stamp_valid,
  output stc_pkg::time_t stamp_value,
  output stc_pkg::time_t video_stamp_now,
  output logic           audio_xrun
);
  import stc_pkg::*;
  initial begin
    ref_valid = 1'b0;
    ref_value = '0;
    stamp_valid = 1'b0;
    stamp_value = '0;
    video_stamp_now = '0;
    audio_xrun = 1'b0;
  end
  // Called just after a rising edge; released data is inverted, not held
  task automatic send_ref(input time_t v);
    ref_valid <= 1'b1;
    ref_value <= v;
    @(posedge pclk);
    ref_valid <= 1'b0;
    ref_value <= ~v;
  endtask
  task automatic send_stamp(input time_t v);
    stamp_valid <= 1'b1;
    stamp_value <= v;
    @(posedge pclk);
    stamp_valid <= 1'b0;
    stamp_value <= ~v;
  endtask
  task automatic pulse_xrun();
    audio_xrun <= 1'b1;
    repeat (2) @(posedge pclk);
    audio_xrun <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the system time block
`include "stc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, step;
  logic        pready, pslverr, er;
  logic        ref_valid, stamp_valid, audio_xrun, video_time_load, audio_time_load, fast_interrupt;
  time_t       ref_value, stamp_value, video_stamp_now, s, refv;
  time_t       system_time_count, video_time_count, audio_time_count;
  logic [41:0] dq [8];
  logic [2:0]  wp;
  logic [7:0]  ra [6] = '{`A_MAXD, `A_GUARD, `A_MARGIN, `A_STEP, `A_AOFF, `A_VOFF};
  logic [31:0] rv [6] = '{`MAXD_RST, `GUARD_RST, `MARGIN_RST, `STEP_RST, 32'h0, 32'h0};
  int          miscompares, comparisons, seed;
  longint      t0, t1;
  always #2 pclk = ~pclk;
  system_time_clock_sync i_system_time_clock_sync (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_valid(ref_valid), .ref_value(ref_value), .stamp_valid(stamp_valid),
    .stamp_value(stamp_value), .video_stamp_now(video_stamp_now), .audio_xrun(audio_xrun),
    .system_time_count(system_time_count), .video_time_count(video_time_count),
    .audio_time_count(audio_time_count), .video_time_load(video_time_load),
    .audio_time_load(audio_time_load), .fast_interrupt(fast_interrupt));
  stream_source i_stream_source (.pclk(pclk), .ref_valid(ref_valid), .ref_value(ref_value),
    .stamp_valid(stamp_valid), .stamp_value(stamp_value), .video_stamp_now(video_stamp_now),
    .audio_xrun(audio_xrun));
  function automatic time_t nxt(input time_t x);
    return (x[8:0] == `PRE_WRAP) ? {x[41:9] + 33'h1, 9'h0} : x + 42'h1;
  endfunction
  function automatic logic [31:0] mean8();
    logic [44:0] t;
    t = '0;
    for (int i = 0; i < 8; i++) begin
      t += 45'(dq[i]);
    end
    return 32'(t >> 3);
  endfunction
  // Load may use the count before or after the edge, incl. the prescaler wrap jump
  function automatic logic near(input time_t a, input time_t b);
    return (a === b) || (a === b - 42'h1) || (a === b - 42'hd5);
  endfunction
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_load(input bit vid, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((vid ? video_time_load : audio_time_load) !== 1'b1 && n < lim);
    if (n >= lim) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic stamp(input logic [41:0] d, input bit keep);
    @(posedge pclk);
    i_stream_source.send_stamp(nxt(system_time_count) + d);
    if (keep) begin
      dq[wp] = d;
      wp++;
    end
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    miscompares = 0;
    comparisons = 0;
    seed = 32'he0b64e50;
    wp = '0;
    foreach (dq[i]) dq[i] = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      check(rd, rv[i]);
    end
    apb(1'b0, `A_STATE, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    s = system_time_count;
    repeat (320) begin
      @(posedge pclk);
      check(system_time_count, nxt(s));
      s = system_time_count;
    end
    apb(1'b1, `A_CTRL, 32'hf);
    apb(1'b0, `A_STATE, 32'h0);
    check(rd, 32'h2);
    refv = 42'($random(seed) & 32'hfff);
    @(posedge pclk);
    i_stream_source.send_ref(refv);
    @(posedge pclk);
    check(system_time_count, refv);
    check(audio_time_count, refv);
    check({video_time_load, audio_time_load}, 2'b11);
    s = refv;
    repeat (5) begin
      @(posedge pclk);
      s = nxt(s);
    end
    check(video_time_count, s);
    apb(1'b0, `A_STATE, 32'h0);
    check(rd, 32'h4);
    for (int i = 0; i < 8; i++) begin
      stamp(42'($random(seed) & 32'hff), 1'b1);
    end
    apb(1'b0, `A_MEAN, 32'h0);
    check(rd, mean8());
    apb(1'b0, `A_STATUS, 32'h0);
    check({rd[`S_DROP], rd[`S_REF]}, 2'b01);
    stamp(42'h10000, 1'b0);
    apb(1'b0, `A_MEAN, 32'h0);
    check(rd, mean8());
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd[`S_DROP], 1'b1);
    apb(1'b1, `A_STATUS, 32'h1f);
    apb(1'b1, `A_GUARD, 32'h0);
    stamp(42'h5, 1'b1);
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd[`S_DROP], 1'b1);
    step = 32'($random(seed) & 32'hf) + 32'h1;
    apb(1'b1, `A_STEP, step);
    apb(1'b1, `A_STATUS, 32'h1f);
    wait_load(1'b0, 20000);
    t0 = $time;
    check(near(audio_time_count, system_time_count), 1'b1);
    repeat (3) @(posedge pclk);
    check(fast_interrupt, 1'b0);
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd[`S_ROLL], 1'b1);
    apb(1'b1, `A_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check(fast_interrupt, 1'b1);
    apb(1'b1, `A_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    check(fast_interrupt, 1'b0);
    wait_load(1'b0, 20000);
    t1 = $time;
    check(64'((t1 - t0) / 4), 64'd19200);
    repeat (3) @(posedge pclk);
    apb(1'b0, `A_VOFF, 32'h0);
    check(rd, 32'(-step));
    apb(1'b0, `A_AOFF, 32'h0);
    check(rd, 32'(-step));
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd[`S_CORR], 1'b1);
    apb(1'b1, `A_CTRL, 32'h1f);
    wait_load(1'b1, 10);
    check(near(video_time_count + 42'(step), system_time_count), 1'b1);
    apb(1'b1, `A_CTRL, 32'h4f);
    apb(1'b0, `A_AOFF, 32'h0);
    check(rd, 32'h0);
    i_stream_source.pulse_xrun();
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd[`S_LIP], 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
